// ==== hdl/vsd_debug_unit.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "vsd_defines.svh"

module vsd_debug_unit #(
	parameter bit DebugEnable = 1'h1
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic [`VSD_AW-1:0]   s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [`VSD_AW-1:0]   s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic [7:0]           s_axis_video_tdata,
	input  wire logic                 s_axis_video_tvalid,
	output logic                      s_axis_video_tready,
	input  wire logic                 s_axis_video_tlast,
	input  wire logic                 s_axis_video_tuser,
	input  wire logic [23:0]          procTdata,
	input  wire logic                 procTvalid,
	output logic                      procTready,
	input  wire logic                 procTlast,
	input  wire logic                 procTuser,
	output logic [23:0]               m_axis_video_tdata,
	output logic                      m_axis_video_tvalid,
	input  wire logic                 m_axis_video_tready,
	output logic                      m_axis_video_tlast,
	output logic                      m_axis_video_tuser
);
	// ============================================================
	// Helpers
	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic isMapped(input logic [`VSD_AW-1:0] a);
		return (a == `VSD_ADDR_CTRL) || (a == `VSD_ADDR_FRAME) || (a == `VSD_ADDR_LINE) ||
			(a == `VSD_ADDR_PIXEL) || (a == `VSD_ADDR_SIZE);
	endfunction

	function automatic vsd_pkg::vsd_src_e srcOf(input logic byp, input logic pat);
		return pat ? vsd_pkg::VSD_SRC_PATTERN : (byp ? vsd_pkg::VSD_SRC_BYPASS : vsd_pkg::VSD_SRC_PROC);
	endfunction

	// Colour index bit 0 red, bit 1 green, bit 2 blue; bus order is R,B,G
	function automatic logic [23:0] barColour(input logic [2:0] idx);
		return {idx[0] ? `VSD_COMP_ON : `VSD_COMP_OFF, idx[2] ? `VSD_COMP_ON : `VSD_COMP_OFF,
			idx[1] ? `VSD_COMP_ON : `VSD_COMP_OFF};
	endfunction

	// ============================================================
	// Declarations
	logic        awReadyQ, awReadyD, bValidQ, bValidD, arReadyQ, arReadyD, rValidQ, rValidD;
	logic [1:0]  bRespQ, bRespD, rRespQ, rRespD;
	logic [31:0] rDataQ, rDataD, sizeQ, sizeD, wrWord;
	logic        bypassQ, bypassD, patternQ, patternD, swRstQ, swRstD;
	logic        wrEn, rdEn;
	logic [31:0] frameQ, frameD, lineQ, lineD, pixelQ, pixelD;
	logic [12:0] xQ, xD, yQ, yD, colsQ, colsD, rowsQ, rowsD;
	logic        sReadyQ, sReadyD, pReadyQ, pReadyD, bufReadyNext, patPush, outFire;
	logic [7:0]  ramp;
	vsd_pkg::vsd_src_e  srcQ, srcD;
	vsd_pkg::vsd_beat_s patBeat;
	vsd_stream_if bufIn ();
	vsd_stream_if bufOut ();

	// ============================================================
	// Register bus handshakes: one write and one read at a time
	assign wrEn = awReadyQ && s_axi_awvalid && s_axi_wvalid;
	assign rdEn = arReadyQ && s_axi_arvalid;
	assign wrWord = mergeBytes(32'h0000_0000, s_axi_wdata, s_axi_wstrb);

	always_comb begin
		awReadyD = s_axi_awvalid && s_axi_wvalid && !awReadyQ && !bValidQ;
		arReadyD = s_axi_arvalid && !arReadyQ && !rValidQ;
		bValidD = wrEn ? 1'h1 : (bValidQ && !s_axi_bready);
		bRespD = wrEn ? (isMapped(s_axi_awaddr) ? `VSD_RESP_OKAY : `VSD_RESP_SLVERR) : bRespQ;
		rValidD = rdEn ? 1'h1 : (rValidQ && !s_axi_rready);
		rRespD = rdEn ? (isMapped(s_axi_araddr) ? `VSD_RESP_OKAY : `VSD_RESP_SLVERR) : rRespQ;
		rDataD = rDataQ;
		if (rdEn) begin
			case (s_axi_araddr)
				`VSD_ADDR_CTRL: begin
					rDataD = '0;
					rDataD[`VSD_CTRL_BYPASS] = bypassQ;
					rDataD[`VSD_CTRL_PATTERN] = patternQ;
					rDataD[`VSD_CTRL_RESET] = swRstQ;
				end
				`VSD_ADDR_FRAME: rDataD = frameQ;
				`VSD_ADDR_LINE:  rDataD = lineQ;
				`VSD_ADDR_PIXEL: rDataD = pixelQ;
				`VSD_ADDR_SIZE:  rDataD = sizeQ;
				default:         rDataD = '0;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awReadyQ <= 1'h0;
			arReadyQ <= 1'h0;
			bValidQ <= 1'h0;
			bRespQ <= `VSD_RESP_OKAY;
			rValidQ <= 1'h0;
			rRespQ <= `VSD_RESP_OKAY;
			rDataQ <= '0;
		end else begin
			awReadyQ <= awReadyD;
			arReadyQ <= arReadyD;
			bValidQ <= bValidD;
			bRespQ <= bRespD;
			rValidQ <= rValidD;
			rRespQ <= rRespD;
			rDataQ <= rDataD;
		end
	end

	// ============================================================
	// Control and size registers; soft reset forces defaults
	always_comb begin
		swRstD = swRstQ;
		bypassD = bypassQ;
		patternD = patternQ;
		sizeD = sizeQ;
		if (wrEn && s_axi_awaddr == `VSD_ADDR_CTRL) begin
			if (s_axi_wstrb[3]) begin
				swRstD = wrWord[`VSD_CTRL_RESET];
			end
			if (s_axi_wstrb[0] && DebugEnable) begin
				bypassD = wrWord[`VSD_CTRL_BYPASS];
				patternD = wrWord[`VSD_CTRL_PATTERN];
			end
		end
		if (wrEn && s_axi_awaddr == `VSD_ADDR_SIZE) begin
			sizeD = mergeBytes(sizeQ, s_axi_wdata, s_axi_wstrb);
		end
		// Counter offsets accept writes but keep their counts
		if (swRstQ || !DebugEnable) begin
			bypassD = 1'h0;
			patternD = 1'h0;
			sizeD = `VSD_SIZE_RESET;
		end
		srcD = srcOf(bypassD, patternD);
		sReadyD = bufReadyNext && srcD == vsd_pkg::VSD_SRC_BYPASS && !swRstD;
		pReadyD = bufReadyNext && srcD == vsd_pkg::VSD_SRC_PROC && !swRstD;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			swRstQ <= 1'h0;
			bypassQ <= 1'h0;
			patternQ <= 1'h0;
			sizeQ <= `VSD_SIZE_RESET;
			srcQ <= vsd_pkg::VSD_SRC_PROC;
			sReadyQ <= 1'h0;
			pReadyQ <= 1'h0;
		end else begin
			swRstQ <= swRstD;
			bypassQ <= bypassD;
			patternQ <= patternD;
			sizeQ <= sizeD;
			srcQ <= srcD;
			sReadyQ <= sReadyD;
			pReadyQ <= pReadyD;
		end
	end

	// ============================================================
	// Test pattern: bars on the top lines, ramp below
	always_comb begin
		ramp = xQ[7:0] + yQ[7:0];
		patBeat.data = (yQ < `VSD_BAR_LINES) ? barColour(xQ[`VSD_BAR_MSB:`VSD_BAR_LSB])
			: {3{ramp}};
		patBeat.user = xQ == 13'h0000 && yQ == 13'h0000;
		patBeat.last = xQ == colsQ - 13'h0001;
		patPush = srcQ == vsd_pkg::VSD_SRC_PATTERN && bufIn.ready && !swRstQ;
		xD = xQ;
		yD = yQ;
		colsD = colsQ;
		rowsD = rowsQ;
		if (srcQ != vsd_pkg::VSD_SRC_PATTERN || swRstQ) begin
			xD = '0;
			yD = '0;
			colsD = sizeQ[`VSD_SIZE_COL_MSB:`VSD_SIZE_COL_LSB];
			rowsD = sizeQ[`VSD_SIZE_ROW_MSB:`VSD_SIZE_ROW_LSB];
		end else if (patPush) begin
			xD = patBeat.last ? 13'h0000 : xQ + 13'h0001;
			if (patBeat.last) begin
				yD = (yQ == rowsQ - 13'h0001) ? 13'h0000 : yQ + 13'h0001;
			end
			// Size is only taken between frames
			if (patBeat.last && yQ == rowsQ - 13'h0001) begin
				colsD = sizeQ[`VSD_SIZE_COL_MSB:`VSD_SIZE_COL_LSB];
				rowsD = sizeQ[`VSD_SIZE_ROW_MSB:`VSD_SIZE_ROW_LSB];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			xQ <= '0;
			yQ <= '0;
			colsQ <= '0;
			rowsQ <= '0;
		end else begin
			xQ <= xD;
			yQ <= yD;
			colsQ <= colsD;
			rowsQ <= rowsD;
		end
	end

	// ============================================================
	// Source multiplexer into the output buffer
	always_comb begin
		case (srcQ)
			vsd_pkg::VSD_SRC_PATTERN: begin
				bufIn.beat = patBeat;
				bufIn.valid = !swRstQ;
			end
			vsd_pkg::VSD_SRC_BYPASS: begin
				bufIn.beat.data = {`VSD_COMP_OFF, `VSD_COMP_OFF, s_axis_video_tdata};
				bufIn.beat.last = s_axis_video_tlast;
				bufIn.beat.user = s_axis_video_tuser;
				bufIn.valid = s_axis_video_tvalid;
			end
			vsd_pkg::VSD_SRC_PROC: begin
				bufIn.beat.data = procTdata;
				bufIn.beat.last = procTlast;
				bufIn.beat.user = procTuser;
				bufIn.valid = procTvalid;
			end
			default: begin
				bufIn.beat = '0;
				bufIn.valid = 1'h0;
			end
		endcase
	end

	vsd_beat_buffer u_buffer (
		.clk       (clk),
		.rst       (rst),
		.flush     (swRstQ),
		.inSide    (bufIn),
		.outSide   (bufOut),
		.readyNext (bufReadyNext)
	);

	assign bufOut.ready = m_axis_video_tready;

	// ============================================================
	// Throughput counters on delivered beats, wrapping at 32 bits
	assign outFire = bufOut.valid && bufOut.ready;

	always_comb begin
		frameD = frameQ;
		lineD = lineQ;
		pixelD = pixelQ;
		if (swRstQ || !DebugEnable) begin
			frameD = '0;
			lineD = '0;
			pixelD = '0;
		end else if (outFire) begin
			pixelD = pixelQ + 32'h0000_0001;
			if (bufOut.beat.last) begin
				lineD = lineQ + 32'h0000_0001;
			end
			if (bufOut.beat.user) begin
				frameD = frameQ + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frameQ <= '0;
			lineQ <= '0;
			pixelQ <= '0;
		end else begin
			frameQ <= frameD;
			lineQ <= lineD;
			pixelQ <= pixelD;
		end
	end

	// ============================================================
	// Port drivers, all from flops
	assign s_axi_awready = awReadyQ;
	assign s_axi_wready = awReadyQ;
	assign s_axi_bvalid = bValidQ;
	assign s_axi_bresp = bRespQ;
	assign s_axi_arready = arReadyQ;
	assign s_axi_rvalid = rValidQ;
	assign s_axi_rresp = rRespQ;
	assign s_axi_rdata = rDataQ;
	assign s_axis_video_tready = sReadyQ;
	assign procTready = pReadyQ;
	assign m_axis_video_tdata = bufOut.beat.data;
	assign m_axis_video_tlast = bufOut.beat.last;
	assign m_axis_video_tuser = bufOut.beat.user;
	assign m_axis_video_tvalid = bufOut.valid;

	// ============================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_ctrl_bypass_set: assert property (wrEn && s_axi_awaddr == `VSD_ADDR_CTRL && s_axi_wstrb[0]
		&& !swRstQ && wrWord[`VSD_CTRL_BYPASS] |=> bypassQ) else $error("bypass bit not taken");
	a_bypass_pass: assert property (s_axis_video_tready |-> bypassQ && !patternQ && bufIn.ready)
		else $error("input accepted outside bypass");
	a_bypass_green: assert property (srcQ == vsd_pkg::VSD_SRC_BYPASS && bufIn.valid && bufIn.ready
		|-> bufIn.beat.data == {16'h0000, s_axis_video_tdata}) else $error("bypass colour wrong");
	a_pattern_red: assert property (patPush && yQ < `VSD_BAR_LINES && xQ[`VSD_BAR_MSB:`VSD_BAR_LSB] == 3'h1
		|-> bufIn.beat.data == 24'hFF0000) else $error("second bar not red");
	a_pattern_black: assert property (patPush && yQ < `VSD_BAR_LINES && xQ[`VSD_BAR_MSB:`VSD_BAR_LSB] == 3'h0
		|-> bufIn.beat.data == 24'h000000) else $error("first bar not black");
	a_ramp_mono: assert property (patPush && yQ >= `VSD_BAR_LINES
		|-> bufIn.beat.data[23:16] == bufIn.beat.data[7:0]
		&& bufIn.beat.data[15:8] == bufIn.beat.data[7:0]) else $error("ramp not monochrome");
	a_pixel_count: assert property (outFire && !swRstQ |=> pixelQ == $past(pixelQ) + 32'h1)
		else $error("pixel count missed");
	a_line_count: assert property (outFire && m_axis_video_tlast && !swRstQ
		|=> lineQ == $past(lineQ) + 32'h1) else $error("line count missed");
	a_frame_count: assert property (outFire && m_axis_video_tuser && !swRstQ
		|=> frameQ == $past(frameQ) + 32'h1) else $error("frame count missed");
	a_swrst_hold: assert property (swRstQ |=> !m_axis_video_tvalid && !s_axis_video_tready
		&& !procTready && pixelQ == 32'h0) else $error("soft reset not holding");
	a_reset_stays: assert property (swRstQ && !(wrEn && s_axi_awaddr == `VSD_ADDR_CTRL)
		|=> swRstQ) else $error("reset bit self cleared");
	a_sof_mark: assert property (patPush && xQ == 13'h0 && yQ == 13'h0 |-> bufIn.beat.user)
		else $error("pattern frame start unmarked");
	a_counter_ro: assert property (wrEn && s_axi_awaddr == `VSD_ADDR_PIXEL && !outFire && !swRstQ
		|=> $stable(pixelQ)) else $error("pixel counter written");

	c_bypass_beat: cover property (srcQ == vsd_pkg::VSD_SRC_BYPASS && outFire);
	c_pattern_ramp: cover property (patPush && yQ >= `VSD_BAR_LINES);
	c_stall_full: cover property (bufOut.valid && !m_axis_video_tready ##1 !bufIn.ready);
	c_soft_reset: cover property (swRstQ ##1 !swRstQ);
endmodule

`default_nettype wire

// ==== inc/vsd_defines.svh ====
`ifndef VSD_DEFINES_SVH
`define VSD_DEFINES_SVH

// ============================================================
// Register map (byte addresses)
`define VSD_AW          9
`define VSD_ADDR_CTRL   9'h000
`define VSD_ADDR_FRAME  9'h014
`define VSD_ADDR_LINE   9'h018
`define VSD_ADDR_PIXEL  9'h01C
`define VSD_ADDR_SIZE   9'h020

// ============================================================
// Control fields
`define VSD_CTRL_BYPASS  4
`define VSD_CTRL_PATTERN 5
`define VSD_CTRL_RESET   30

// ============================================================
// Frame size fields and reset value
`define VSD_SIZE_COL_LSB 0
`define VSD_SIZE_COL_MSB 12
`define VSD_SIZE_ROW_LSB 16
`define VSD_SIZE_ROW_MSB 28
`define VSD_SIZE_RESET   32'h0438_0780

// ============================================================
// Pattern generator geometry
`define VSD_BAR_LINES 13'h0100
`define VSD_BAR_LSB   6
`define VSD_BAR_MSB   8
`define VSD_COMP_ON   8'hFF
`define VSD_COMP_OFF  8'h00

// ============================================================
// Bus answers
`define VSD_RESP_OKAY   2'h0
`define VSD_RESP_SLVERR 2'h2

`endif

// ==== inc/vsd_pkg.sv ====
`default_nettype none

package vsd_pkg;

	// ============================================================
	// Stream beat carried through the output buffer
	typedef struct packed {
		logic        user;
		logic        last;
		logic [23:0] data;
	} vsd_beat_s;

	// Which source feeds the output stream
	typedef enum logic [1:0] {
		VSD_SRC_PROC,
		VSD_SRC_BYPASS,
		VSD_SRC_PATTERN
	} vsd_src_e;

endpackage

`default_nettype wire

// ==== inc/vsd_stream_if.sv ====
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Beat stream between the debug unit and its buffer
interface vsd_stream_if;
	vsd_pkg::vsd_beat_s beat;
	logic               valid;
	logic               ready;

	modport src (output beat, output valid, input ready);
	modport snk (input beat, input valid, output ready);
endinterface

`default_nettype wire

// ==== hdl/vsd_beat_buffer.sv ====
`timescale 1ns/10ps
`default_nettype none

module vsd_beat_buffer (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic flush,
	vsd_stream_if.snk inSide,
	vsd_stream_if.src outSide,
	output logic      readyNext
);
	vsd_pkg::vsd_beat_s headQ;
	vsd_pkg::vsd_beat_s headD;
	vsd_pkg::vsd_beat_s skidQ;
	vsd_pkg::vsd_beat_s skidD;
	logic               headVldQ;
	logic               headVldD;
	logic               skidVldQ;
	logic               skidVldD;
	logic               readyQ;
	logic               push;
	logic               pop;

	// ============================================================
	// Head drives the output, skid holds a beat taken during a stall
	always_comb begin
		push = inSide.valid && readyQ;
		pop = headVldQ && outSide.ready;
		headD = headQ;
		headVldD = headVldQ;
		skidD = skidQ;
		skidVldD = skidVldQ;
		if (!headVldQ || pop) begin
			if (skidVldQ) begin
				headD = skidQ;
				headVldD = 1'h1;
				skidVldD = push;
				if (push) begin
					skidD = inSide.beat;
				end
			end else begin
				headVldD = push;
				if (push) begin
					headD = inSide.beat;
				end
			end
		end else if (push) begin
			skidVldD = 1'h1;
			skidD = inSide.beat;
		end
		// Flush drops both entries and stops taking beats
		if (flush) begin
			headVldD = 1'h0;
			skidVldD = 1'h0;
		end
		readyNext = !skidVldD && !flush;
	end

	// Register the buffer state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			headQ <= '0;
			skidQ <= '0;
			headVldQ <= 1'h0;
			skidVldQ <= 1'h0;
			readyQ <= 1'h0;
		end else begin
			headQ <= headD;
			skidQ <= skidD;
			headVldQ <= headVldD;
			skidVldQ <= skidVldD;
			readyQ <= readyNext;
		end
	end

	// Outputs straight from the flops
	assign inSide.ready = readyQ;
	assign outSide.beat = headQ;
	assign outSide.valid = headVldQ;
endmodule

`default_nettype wire

// ==== sim/vsd_video_partner.sv ====
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Upstream sources and downstream sink around the debug unit
module vsd_video_partner (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        srcEn,
	input  wire logic        stallEn,
	input  wire logic        sTready,
	input  wire logic        pTready,
	output logic [7:0]       sTdata,
	output logic [23:0]      pTdata,
	output logic             tValid,
	output logic             tLast,
	output logic             tUser,
	output logic             mTready
);
	logic [7:0] seqQ;
	logic       holdQ;
	logic [1:0] phaseQ;
	logic       taken;

	// Beat index is the sample; idle lines show its inverse
	assign taken   = holdQ & (sTready | pTready);
	assign tValid  = holdQ;
	assign sTdata  = holdQ ? seqQ : ~seqQ;
	assign pTdata  = holdQ ? {~seqQ, 8'h5A, seqQ} : {seqQ, 8'hA5, ~seqQ};
	assign tLast   = seqQ[1:0] == 2'h3;
	assign tUser   = seqQ[2:0] == 3'h0;
	assign mTready = ~stallEn | (phaseQ == 2'h3);

	// Offer a beat and hold it until a ready takes it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seqQ   <= 8'h00;
			holdQ  <= 1'h0;
			phaseQ <= 2'h0;
		end else begin
			phaseQ <= phaseQ + 2'h1;
			if (taken)
				seqQ <= seqQ + 8'h01;
			if (taken | ~holdQ)
				holdQ <= srcEn & (~stallEn | phaseQ[0]);
		end
	end
endmodule

`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "vsd_defines.svh"

module tb;
	logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, sReady, pReady, tValid, tLast, tUser;
	logic        mValid, mReady, mLast, mUser, srcEn, stallEn;
	logic [8:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [3:0]  strb;
	logic [7:0]  sData, eIdx;
	logic [23:0] pData, mData, eData;
	logic [12:0] x, y, cols, rows;
	logic [2:0]  bar;
	int          mode, beats, expPix, expLine, expFrame, errorCnt, nChecks;

	vsd_debug_unit u_vsd_debug_unit (.clk(clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axis_video_tdata(sData), .s_axis_video_tvalid(tValid), .s_axis_video_tready(sReady),
		.s_axis_video_tlast(tLast), .s_axis_video_tuser(tUser),
		.procTdata(pData), .procTvalid(tValid), .procTready(pReady), .procTlast(tLast), .procTuser(tUser),
		.m_axis_video_tdata(mData), .m_axis_video_tvalid(mValid), .m_axis_video_tready(mReady),
		.m_axis_video_tlast(mLast), .m_axis_video_tuser(mUser));

	vsd_video_partner u_vsd_video_partner (.clk(clk), .rst(rst), .srcEn(srcEn), .stallEn(stallEn),
		.sTready(sReady), .pTready(pReady), .sTdata(sData), .pTdata(pData), .tValid(tValid),
		.tLast(tLast), .tUser(tUser), .mTready(mReady));

	// Clock
	initial clk = 1'h0;
	always #5 clk = ~clk;

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp) begin
			errorCnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic testDone;
		if (errorCnt == 0 && nChecks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Register write: hold request until the ready edge, then take the answer
	task automatic wr(input logic [8:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		#1 awaddr = a;
		wdata = d;
		awvalid = 1'h1;
		wvalid = 1'h1;
		do @(posedge clk); while (awready !== 1'h1);
		check({31'h0, wready}, 32'h1);
		#1 awvalid = 1'h0;
		wvalid = 1'h0;
		bready = 1'h1;
		do @(posedge clk); while (bvalid !== 1'h1);
		check({30'h0, bresp}, {30'h0, er});
		#1 bready = 1'h0;
	endtask

	// Register read
	task automatic rd(input logic [8:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		#1 araddr = a;
		arvalid = 1'h1;
		do @(posedge clk); while (arready !== 1'h1);
		#1 arvalid = 1'h0;
		rready = 1'h1;
		do @(posedge clk); while (rvalid !== 1'h1);
		check(rdata, e);
		check({30'h0, rresp}, {30'h0, er});
		#1 rready = 1'h0;
	endtask

	// Wait until the output has stayed empty for four edges
	task automatic drain;
		int q;
		q = 0;
		while (q < 4) begin
			@(posedge clk);
			q = (mValid === 1'h0) ? q + 1 : 0;
		end
		#1;
	endtask

	// Read all three throughput counters
	task automatic rdCounts;
		rd(`VSD_ADDR_FRAME, 32'(expFrame), `VSD_RESP_OKAY);
		rd(`VSD_ADDR_LINE, 32'(expLine), `VSD_RESP_OKAY);
		rd(`VSD_ADDR_PIXEL, 32'(expPix), `VSD_RESP_OKAY);
	endtask

	// Arm the pattern tracker for a fresh frame
	task automatic armPattern(input logic [12:0] c, input logic [12:0] r);
		x = 13'h0000;
		y = 13'h0000;
		cols = c;
		rows = r;
		beats = 0;
		mode = 2;
	endtask

	// Output monitor: every delivered beat against its expected value
	always @(posedge clk) begin
		if (mValid === 1'h1 && mReady === 1'h1) begin
			beats++;
			if (mode == 2) begin
				bar = x[8:6];
				eData = (y < `VSD_BAR_LINES) ? {bar[0] ? 8'hFF : 8'h00, bar[2] ? 8'hFF : 8'h00,
					bar[1] ? 8'hFF : 8'h00} : {3{x[7:0] + y[7:0]}};
				check({8'h00, mData}, {8'h00, eData});
				check({30'h0, mLast, mUser}, {30'h0, x == cols - 13'h1, x == 13'h0 && y == 13'h0});
				expLine += int'(x == cols - 13'h1);
				expFrame += int'(x == 13'h0 && y == 13'h0);
				y = (x != cols - 13'h1) ? y : (y == rows - 13'h1) ? 13'h0000 : y + 13'h1;
				x = (x == cols - 13'h1) ? 13'h0000 : x + 13'h1;
			end else begin
				eData = (mode == 1) ? {16'h0000, eIdx} : {~eIdx, 8'h5A, eIdx};
				check({8'h00, mData}, {8'h00, eData});
				check({30'h0, mLast, mUser}, {30'h0, eIdx[1:0] == 2'h3, eIdx[2:0] == 3'h0});
				expLine += int'(eIdx[1:0] == 2'h3);
				expFrame += int'(eIdx[2:0] == 3'h0);
				eIdx = eIdx + 8'h01;
			end
			expPix++;
		end
	end

	// Watchdog against a hang
	initial begin
		#300us;
		errorCnt++;
		testDone;
	end

	// Main sequence
	initial begin
		{awaddr, araddr, wdata, eIdx, x, y, cols, rows} = '0;
		{awvalid, wvalid, bready, arvalid, rready, srcEn, stallEn} = '0;
		{mode, beats, expPix, expLine, expFrame, errorCnt, nChecks} = '0;
		strb = 4'hF;
		rst = 1'h1;
		repeat (16) @(posedge clk);
		#1 rst = 1'h0;
		// Reset values, unmapped place, read-only counters
		rdCounts;
		rd(`VSD_ADDR_CTRL, 32'h0, `VSD_RESP_OKAY);
		rd(`VSD_ADDR_SIZE, `VSD_SIZE_RESET, `VSD_RESP_OKAY);
		rd(9'h040, 32'h0, `VSD_RESP_SLVERR);
		wr(9'h040, 32'hFFFF_FFFF, `VSD_RESP_SLVERR);
		wr(`VSD_ADDR_PIXEL, 32'h1234_5678, `VSD_RESP_OKAY);
		rd(`VSD_ADDR_PIXEL, 32'h0, `VSD_RESP_OKAY);
		// Processing path with a stalling receiver
		stallEn = 1'h1;
		srcEn = 1'h1;
		while (beats < 24) @(posedge clk);
		#1 srcEn = 1'h0;
		drain;
		// Bypass path at full rate; processing input refused
		wr(`VSD_ADDR_CTRL, 32'h0000_0010, `VSD_RESP_OKAY);
		rd(`VSD_ADDR_CTRL, 32'h0000_0010, `VSD_RESP_OKAY);
		mode = 1;
		beats = 0;
		stallEn = 1'h0;
		srcEn = 1'h1;
		while (beats < 16) begin
			@(posedge clk);
			check({31'h0, pReady}, 32'h0);
		end
		#1 srcEn = 1'h0;
		drain;
		rdCounts;
		// Colour bars past the 512th pixel, then soft reset mid-frame
		wr(`VSD_ADDR_SIZE, 32'h0002_0202, `VSD_RESP_OKAY);
		armPattern(13'h0202, 13'h0002);
		wr(`VSD_ADDR_CTRL, 32'h0000_0020, `VSD_RESP_OKAY);
		stallEn = 1'h1;
		while (beats < 1029) @(posedge clk);
		#1 wr(`VSD_ADDR_CTRL, 32'h4000_0000, `VSD_RESP_OKAY);
		check({29'h0, sReady, pReady, mValid}, 32'h0);
		{expPix, expLine, expFrame} = '0;
		rdCounts;
		rd(`VSD_ADDR_SIZE, `VSD_SIZE_RESET, `VSD_RESP_OKAY);
		// Mode bits ignored in soft reset; reset bit needs its own byte lane
		strb = 4'h1;
		wr(`VSD_ADDR_CTRL, 32'h0000_0030, `VSD_RESP_OKAY);
		strb = 4'hF;
		rd(`VSD_ADDR_CTRL, 32'h4000_0000, `VSD_RESP_OKAY);
		check({29'h0, sReady, pReady, mValid}, 32'h0);
		wr(`VSD_ADDR_CTRL, 32'h0, `VSD_RESP_OKAY);
		// Ramp below the bar lines, across a frame wrap
		wr(`VSD_ADDR_SIZE, 32'h0104_0004, `VSD_RESP_OKAY);
		armPattern(13'h0004, 13'h0104);
		wr(`VSD_ADDR_CTRL, 32'h0000_0020, `VSD_RESP_OKAY);
		rd(`VSD_ADDR_CTRL, 32'h0000_0020, `VSD_RESP_OKAY);
		while (beats < 1041) @(posedge clk);
		#1 wr(`VSD_ADDR_CTRL, 32'h0, `VSD_RESP_OKAY);
		stallEn = 1'h0;
		drain;
		// Normal processing input is offered again, bypass input is not
		check({30'h0, sReady, pReady}, 32'h1);
		rd(`VSD_ADDR_CTRL, 32'h0, `VSD_RESP_OKAY);
		rdCounts;
		testDone;
	end
endmodule

`default_nettype wire
